// ### include/dsc_pkg.sv
// Constants, types and register map of the digit segment and ASCII converter
package dsc_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int unsigned DSC_DATA_W = 16;
  localparam int unsigned DSC_ADDR_W = 8;

  // ****************************************
  // Register word addresses
  // ****************************************
  localparam logic [7:0] DSC_REG_CTRL = 8'h00;
  localparam logic [7:0] DSC_REG_SRC = 8'h01;
  localparam logic [7:0] DSC_REG_DSG = 8'h02;
  localparam logic [7:0] DSC_REG_DST = 8'h03;
  localparam logic [7:0] DSC_REG_STAT = 8'h04;
  localparam logic [7:0] DSC_REG_MASK = 8'h05;
  localparam logic [7:0] DSC_REG_FLAG = 8'h06;
  localparam logic [7:0] DSC_REG_AREA = 8'h80;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int unsigned DSC_CTRL_EXEC_BIT = 0;
  localparam int unsigned DSC_CTRL_OP_BIT = 1;
  localparam int unsigned DSC_CTRL_BUSY_BIT = 8;
  localparam int unsigned DSC_STAT_DONE_BIT = 0;
  localparam int unsigned DSC_STAT_ERR_BIT = 1;
  localparam logic [15:0] DSC_WORD_RST = 16'h0000;
  localparam logic [1:0] DSC_EVT_RST = 2'h0;
  localparam logic [7:0] DSC_DST_RST = 8'h00;

  // ****************************************
  // Designator field values
  // ****************************************
  localparam logic [3:0] DSC_MAX_DIGIT = 4'h3;
  localparam logic [3:0] DSC_HALF_HIGH = 4'h1;
  localparam logic [3:0] DSC_PAR_NONE = 4'h0;
  localparam logic [3:0] DSC_PAR_EVEN = 4'h1;
  localparam logic [3:0] DSC_PAR_ODD = 4'h2;
  localparam logic [7:0] DSC_ASC_DIGIT_BASE = 8'h30;
  localparam logic [7:0] DSC_ASC_ALPHA_BASE = 8'h37;
  localparam logic [3:0] DSC_ASC_ALPHA_FIRST = 4'ha;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [3:0] parity;
    logic [3:0] half;
    logic [3:0] count_m1;
    logic [3:0] first;
  } dsc_desig_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } dsc_bus_req_t;

  typedef enum logic [1:0] {
    DSC_IDLE,
    DSC_RUN
  } dsc_state_t;

endpackage

// ### hw/dsc_converter.sv
// Execution unit for seven-segment and ASCII digit conversion
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module dsc_converter #(
  parameter int unsigned DATA_WORDS = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire dsc_pkg::dsc_bus_req_t bus_req,
  output logic [dsc_pkg::DSC_DATA_W-1:0] rd_data,
  output logic irq,
  output logic error_flag,
  output logic busy
);
  import dsc_pkg::*;

  localparam int unsigned AW = (DATA_WORDS > 1) ? $clog2(DATA_WORDS) : 1;
  localparam logic [8:0] AREA_WORDS = 9'(DATA_WORDS);

  // ****************************************
  // Conversion functions
  // ****************************************

  // Segment a in bit 0 up to g in bit 6, bit 7 clear
  function automatic logic [7:0] seg_code(input logic [3:0] nib);
    logic [7:0] c;
    c = 8'h00;
    case (nib)
      4'h0: c = 8'h3f;
      4'h1: c = 8'h06;
      4'h2: c = 8'h5b;
      4'h3: c = 8'h4f;
      4'h4: c = 8'h66;
      4'h5: c = 8'h6d;
      4'h6: c = 8'h7d;
      4'h7: c = 8'h27;
      4'h8: c = 8'h7f;
      4'h9: c = 8'h6f;
      4'ha: c = 8'h77;
      4'hb: c = 8'h7c;
      4'hc: c = 8'h39;
      4'hd: c = 8'h5e;
      4'he: c = 8'h79;
      4'hf: c = 8'h71;
      default: c = 8'h00;
    endcase
    return c;
  endfunction

  // Character code for one nibble, parity in bit 7
  function automatic logic [7:0] asc_code(input logic [3:0] nib, input logic [3:0] par);
    logic [7:0] c;
    logic ones;
    c = 8'h00;
    ones = 1'b0;
    if (nib < DSC_ASC_ALPHA_FIRST) begin
      c = DSC_ASC_DIGIT_BASE + {4'h0, nib};
    end else begin
      c = DSC_ASC_ALPHA_BASE + {4'h0, nib};
    end
    ones = ^c[6:0];
    case (par)
      DSC_PAR_EVEN: c[7] = ones;
      DSC_PAR_ODD: c[7] = ~ones;
      default: c[7] = 1'b0;
    endcase
    return c;
  endfunction

  // Register write strobe for one word address
  function automatic logic reg_wr(input dsc_bus_req_t r, input logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  // Designator check for either operation
  function automatic logic desig_ok(input dsc_desig_t d, input logic ascii);
    logic ok;
    ok = (d.first <= DSC_MAX_DIGIT) && (d.count_m1 <= DSC_MAX_DIGIT) &&
         (d.half <= DSC_HALF_HIGH);
    if (ascii) begin
      ok = ok && (d.parity <= DSC_PAR_ODD);
    end else begin
      ok = ok && (d.parity == DSC_PAR_NONE);
    end
    return ok;
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  logic [DSC_DATA_W-1:0] src_q;
  dsc_desig_t dsg_q;
  logic [7:0] dst_q;
  logic [1:0] stat_q;
  logic [1:0] stat_d;
  logic [1:0] mask_q;
  logic [DSC_DATA_W-1:0] area_q [DATA_WORDS];
  logic [DSC_DATA_W-1:0] rd_data_q;
  logic irq_q;
  logic error_flag_q;
  logic busy_q;
  logic area_hit;
  logic [AW-1:0] area_idx;
  logic wr_ctrl;
  logic wr_src;
  logic wr_dsg;
  logic wr_dst;
  logic wr_stat;
  logic wr_mask;
  logic start_ok;
  logic start_bad;
  logic done_evt;

  // Data area window above the control registers
  assign area_hit = (bus_req.addr >= DSC_REG_AREA) &&
                    ({1'b0, bus_req.addr - DSC_REG_AREA} < AREA_WORDS);
  assign area_idx = AW'(bus_req.addr - DSC_REG_AREA);
  assign wr_ctrl = reg_wr(bus_req, DSC_REG_CTRL);

  // Write strobes of the individual registers
  assign wr_src = reg_wr(bus_req, DSC_REG_SRC);
  assign wr_dsg = reg_wr(bus_req, DSC_REG_DSG);
  assign wr_dst = reg_wr(bus_req, DSC_REG_DST);
  assign wr_stat = reg_wr(bus_req, DSC_REG_STAT);
  assign wr_mask = reg_wr(bus_req, DSC_REG_MASK);

  // ****************************************
  // Instruction launch
  // ****************************************
  dsc_state_t state_q;
  logic op_ascii_q;
  logic [1:0] digit_q;
  logic [1:0] left_q;
  logic [AW-1:0] wptr_q;
  logic half_q;
  logic [3:0] par_q;
  logic [8:0] last_word;
  logic launch;
  logic launch_ascii;

  // Launch only with the execution condition on and the unit idle
  assign launch = wr_ctrl && bus_req.wdata[DSC_CTRL_EXEC_BIT] && !busy_q;
  assign launch_ascii = bus_req.wdata[DSC_CTRL_OP_BIT];

  // Last destination word touched by this conversion
  assign last_word = {1'b0, dst_q} +
                     9'(({1'b0, dsg_q.half[0]} + {1'b0, dsg_q.count_m1[1:0]}) >> 1);

  // Area fits and designator fields are in range
  assign start_ok = launch && desig_ok(dsg_q, launch_ascii) &&
                    (last_word < AREA_WORDS);
  assign start_bad = launch && !start_ok;

  // ****************************************
  // Conversion engine
  // ****************************************
  logic [3:0] cur_nib;
  logic [7:0] cur_code;

  // Current source digit and its code
  assign cur_nib = src_q[{digit_q, 2'b00} +: 4];
  assign cur_code = op_ascii_q ? asc_code(cur_nib, par_q) : seg_code(cur_nib);
  assign done_evt = (state_q == DSC_RUN) && (left_q == 2'd0);

  // Sequencer, one byte per cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= DSC_IDLE;
      op_ascii_q <= 1'b0;
      digit_q <= 2'd0;
      left_q <= 2'd0;
      wptr_q <= '0;
      half_q <= 1'b0;
      par_q <= DSC_PAR_NONE;
    end else begin
      case (state_q)
        DSC_IDLE: begin
          // Capture the designator fields for the whole run
          if (start_ok) begin
            state_q <= DSC_RUN;
            op_ascii_q <= launch_ascii;
            digit_q <= dsg_q.first[1:0];
            left_q <= dsg_q.count_m1[1:0];
            wptr_q <= AW'(dst_q);
            half_q <= dsg_q.half[0];
            par_q <= dsg_q.parity;
          end
        end
        DSC_RUN: begin
          digit_q <= digit_q + 2'd1;
          half_q <= ~half_q;
          if (half_q) begin
            wptr_q <= wptr_q + AW'(1);
          end
          // Last code lands this cycle, back to idle
          if (left_q == 2'd0) begin
            state_q <= DSC_IDLE;
          end else begin
            left_q <= left_q - 2'd1;
          end
        end
        default: begin
          state_q <= DSC_IDLE;
        end
      endcase
    end
  end

  // Data area: engine writes bytes, bus writes words when idle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < int'(DATA_WORDS); i++) begin
        area_q[i] <= DSC_WORD_RST;
      end
    end else if (state_q == DSC_RUN) begin
      // High lane while the half pointer is set
      if (half_q) begin
        area_q[wptr_q][15:8] <= cur_code;
      end else begin
        area_q[wptr_q][7:0] <= cur_code;
      end
    end else if (bus_req.wr && area_hit) begin
      area_q[area_idx] <= bus_req.wdata;
    end
  end

  // ****************************************
  // Operand registers
  // ****************************************

  // Operands hold steady while a conversion runs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      src_q <= DSC_WORD_RST;
      dsg_q <= DSC_WORD_RST;
      dst_q <= DSC_DST_RST;
    end else if (!busy_q) begin
      if (wr_src) begin
        src_q <= bus_req.wdata;
      end
      if (wr_dsg) begin
        dsg_q <= bus_req.wdata;
      end
      if (wr_dst) begin
        dst_q <= bus_req.wdata[7:0];
      end
    end
  end

  // Error flag reflects the most recent executed instruction
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      error_flag_q <= 1'b0;
    end else if (start_bad) begin
      error_flag_q <= 1'b1;
    end else if (start_ok) begin
      error_flag_q <= 1'b0;
    end
  end

  // Busy covers the whole conversion
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_q <= 1'b0;
    end else if (start_ok) begin
      busy_q <= 1'b1;
    end else if (done_evt) begin
      busy_q <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************

  // Sticky events, a new event beats a same-cycle clear
  always_comb begin
    stat_d = stat_q;
    // Software clear first, events below override it
    if (wr_stat) begin
      stat_d = stat_q & ~bus_req.wdata[1:0];
    end
    if (done_evt) begin
      stat_d[DSC_STAT_DONE_BIT] = 1'b1;
    end
    if (start_bad) begin
      stat_d[DSC_STAT_ERR_BIT] = 1'b1;
    end
  end

  // Status, mask and interrupt line
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      stat_q <= DSC_EVT_RST;
      mask_q <= DSC_EVT_RST;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q <= |(stat_d & mask_q);
      // A new mask acts on the line at once
      if (wr_mask) begin
        mask_q <= bus_req.wdata[1:0];
        irq_q <= |(stat_d & bus_req.wdata[1:0]);
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************

  // Read data the cycle after the strobe, zero elsewhere
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_q <= DSC_WORD_RST;
    end else begin
      rd_data_q <= DSC_WORD_RST;
      if (bus_req.rd) begin
        // Data area first, then the register decode
        if (area_hit) begin
          rd_data_q <= area_q[area_idx];
        end else begin
          case (bus_req.addr)
            DSC_REG_CTRL: rd_data_q[DSC_CTRL_BUSY_BIT] <= busy_q;
            DSC_REG_SRC: rd_data_q <= src_q;
            DSC_REG_DSG: rd_data_q <= dsg_q;
            DSC_REG_DST: rd_data_q[7:0] <= dst_q;
            DSC_REG_STAT: rd_data_q[1:0] <= stat_q;
            DSC_REG_MASK: rd_data_q[1:0] <= mask_q;
            DSC_REG_FLAG: rd_data_q[0] <= error_flag_q;
            default: rd_data_q <= DSC_WORD_RST;
          endcase
        end
      end
    end
  end

  // Outputs straight from flip-flops
  assign rd_data = rd_data_q;
  assign irq = irq_q;
  assign error_flag = error_flag_q;
  assign busy = busy_q;

endmodule
`default_nettype wire

// ### verif/dsc_converter_monitor.sv
// Checker of port timing for the digit converter
`timescale 1ns/100ps
`default_nettype none
module dsc_converter_monitor #(
  parameter int unsigned DATA_WORDS = 16
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire dsc_pkg::dsc_bus_req_t bus_req,
  input wire logic [dsc_pkg::DSC_DATA_W-1:0] rd_data,
  input wire logic irq,
  input wire logic error_flag,
  input wire logic busy
);
  import dsc_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  logic launch_q;
  // ****************************************
  // Launch seen at the previous edge
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) launch_q <= 1'b0;
    else launch_q <= bus_req.wr && bus_req.addr == DSC_REG_CTRL && bus_req.wdata[0];
  end
  sequence ctrl_s;
    bus_req.wr && bus_req.addr == DSC_REG_CTRL;
  endsequence
  sequence launch_s;
    ctrl_s ##0 bus_req.wdata[0] && !busy;
  endsequence
  chk_read_idle: assert property (!bus_req.rd |=> rd_data == 16'h0000)
    else $error("read data not zero outside read slot");
  chk_launch_reply: assert property (launch_s |=> busy ^ error_flag)
    else $error("launch gave neither busy nor error");
  chk_busy_len: assert property ($rose(busy) |-> ##[1:4] !busy)
    else $error("busy longer than four cycles");
  chk_busy_cause: assert property ($rose(busy) |-> launch_q)
    else $error("busy rose without a launch");
  chk_err_idle: assert property (error_flag |-> !busy)
    else $error("error flag while busy");
  chk_exec_off: assert property (ctrl_s ##0 !bus_req.wdata[0] && !busy
    |=> !busy && $stable(error_flag))
    else $error("condition off changed state");
  chk_flag_hold: assert property (!bus_req.wr |=> $stable(error_flag))
    else $error("error flag moved without a write");
  chk_busy_refuse: assert property (busy && bus_req.wr |=> !error_flag)
    else $error("write while busy raised error");
endmodule
bind dsc_converter dsc_converter_monitor #(.DATA_WORDS(DATA_WORDS)) u_mon (
  .ref_clk(ref_clk), .resetn(resetn), .bus_req(bus_req), .rd_data(rd_data),
  .irq(irq), .error_flag(error_flag), .busy(busy));
`default_nettype wire

// ### verif/dsc_converter_bench.sv
// Self-checking bench for the digit converter
`timescale 1ns/100ps
`default_nettype none
module dsc_converter_bench;
  import dsc_pkg::*;
  localparam int NW = 4;
  localparam logic [7:0] SEG [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h27,
    8'h7f, 8'h6f, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
  localparam logic [7:0] RA [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h80,
    8'h40};
  logic ref_clk, resetn, irq, error_flag, busy, perr, bad;
  dsc_bus_req_t bus_req;
  logic [15:0] rd_data, v;
  logic [15:0] mem [NW];
  int err_total, tests_run;
  dsc_converter #(.DATA_WORDS(NW)) DUT (.ref_clk(ref_clk), .resetn(resetn),
    .bus_req(bus_req), .rd_data(rd_data), .irq(irq), .error_flag(error_flag), .busy(busy));
  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    close_out();
  end
  // ****************************************
  // Bus cycles, compare and model
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    bus_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge ref_clk);
    bus_req <= '0;
    #1 v = rd_data;
  endtask
  function automatic logic [7:0] code(input logic o, input logic [3:0] d, input logic [3:0] q);
    logic [7:0] c;
    c = (d < 4'ha) ? 8'h30 + d : 8'h41 + d - 8'h0a;
    c[7] = (q == 4'h1) ? ^c[6:0] : (q == 4'h2) ? ~^c[6:0] : 1'b0;
    return o ? c : SEG[d];
  endfunction
  // One instruction: preload area, launch, predict and compare
  task automatic conv(input logic o, input logic e, input logic [3:0] f, input logic [3:0] c,
    input logic [3:0] h, input logic [3:0] q, input logic [7:0] d, input logic [15:0] s);
    int i;
    logic [3:0] pos;
    for (i = 0; i < NW; i++) begin
      mem[i] = 16'($urandom);
      wr(DSC_REG_AREA + 8'(i), mem[i]);
    end
    wr(DSC_REG_STAT, 16'h0003);
    wr(DSC_REG_SRC, s);
    wr(DSC_REG_DSG, {q, h, c, f});
    wr(DSC_REG_DST, {8'h00, d});
    wr(DSC_REG_CTRL, {14'h0, o, e});
    bad = f > 3 || h > 1 || (o ? q > 2 : q != 0) || d + ((h + c) >> 1) >= NW;
    i = 0;
    #1;
    while (busy === 1'b1 && i < 8) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    chk("busy cycles", 16'(i), (e && !bad) ? 16'(c) + 16'h0001 : 16'h0000);
    if (e) begin
      perr = bad;
      if (!bad) for (i = 0; i <= c; i++) begin
        pos = h + 4'(i);
        mem[d + pos[3:1]][pos[0]*8 +: 8] = code(o, s[((f + i) % 4)*4 +: 4], q);
      end
    end
    chk("error_flag", {15'h0, error_flag}, {15'h0, perr});
    rd(DSC_REG_STAT);
    chk("status", v, e ? {14'h0, bad, ~bad} : 16'h0000);
    for (i = 0; i < NW; i++) begin
      rd(DSC_REG_AREA + 8'(i));
      chk("area word", v, mem[i]);
    end
  endtask
  task automatic close_out();
    $display("tests_run %0d err_total %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    bus_req = '0;
    resetn = 1'b0;
    err_total = 0;
    tests_run = 0;
    perr = 1'b0;
    void'($urandom(32'hd979));
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    // Reset values, unmapped hole ignores writes
    wr(8'h40, 16'hffff);
    foreach (RA[i]) begin
      rd(RA[i]);
      chk("reset value", v, 16'h0000);
    end
    // Corners: parity example, wrap, overrun, bad parity, condition off
    conv(1'b1, 1'b1, 4'h1, 4'h0, 4'h0, 4'h1, 8'h00, 16'h0010);
    conv(1'b0, 1'b1, 4'h3, 4'h3, 4'h1, 4'h0, 8'h00, 16'h8421);
    conv(1'b0, 1'b1, 4'h0, 4'h3, 4'h1, 4'h0, 8'h02, 16'h1234);
    conv(1'b1, 1'b1, 4'h0, 4'h0, 4'h0, 4'h3, 8'h00, 16'h0005);
    conv(1'b0, 1'b0, 4'h0, 4'h3, 4'h0, 4'h0, 8'h00, 16'hffff);
    for (int k = 0; k < 40; k++)
      conv(1'($urandom_range(0, 1)), $urandom_range(0, 3) != 0, 4'($urandom_range(0, 4)),
        4'($urandom_range(0, 3)), 4'($urandom_range(0, 2)), 4'($urandom_range(0, 3)),
        8'($urandom_range(0, 4)), 16'($urandom));
    // Busy window: refused operand write, busy bit, readback
    wr(DSC_REG_SRC, 16'h5a3c);
    wr(DSC_REG_DSG, 16'h0030);
    wr(DSC_REG_DST, 16'h0000);
    wr(DSC_REG_CTRL, 16'h0001);
    wr(DSC_REG_SRC, 16'hffff);
    rd(DSC_REG_CTRL);
    chk("busy bit", v, 16'h0100);
    rd(DSC_REG_SRC);
    chk("source kept", v, 16'h5a3c);
    rd(DSC_REG_DSG);
    chk("designator", v, 16'h0030);
    rd(DSC_REG_AREA);
    chk("area word", v, {SEG[3], SEG[12]});
    rd(DSC_REG_AREA + 8'h01);
    chk("area word", v, {SEG[5], SEG[10]});
    // Interrupt: masked, unmasked, cleared, error event
    wr(DSC_REG_MASK, 16'h0002);
    conv(1'b0, 1'b1, 4'h0, 4'h1, 4'h0, 4'h0, 8'h01, 16'h00c7);
    chk("irq masked", {15'h0, irq}, 16'h0000);
    wr(DSC_REG_MASK, 16'h0003);
    @(posedge ref_clk);
    #1 chk("irq done", {15'h0, irq}, 16'h0001);
    wr(DSC_REG_STAT, 16'h0003);
    @(posedge ref_clk);
    #1 chk("irq cleared", {15'h0, irq}, 16'h0000);
    wr(DSC_REG_MASK, 16'h0002);
    conv(1'b0, 1'b1, 4'h4, 4'h0, 4'h0, 4'h0, 8'h00, 16'h0001);
    chk("irq error", {15'h0, irq}, 16'h0001);
    close_out();
  end
endmodule
`default_nettype wire
